// ### inc/rhd_pkg.sv
// Constants for the root hub descriptor register bank
package rhd_pkg;
    localparam int DATA_W = 32;
    localparam int CODE_W = 8;
    localparam int PORTS  = 2;

    // Command codes; a write code is its read code with bit 7 set
    localparam logic [7:0] CODE_DESC_FIRST_RD  = 8'h12;
    localparam logic [7:0] CODE_DESC_FIRST_WR  = 8'h92;
    localparam logic [7:0] CODE_DESC_SECOND_RD = 8'h13;
    localparam logic [7:0] CODE_DESC_SECOND_WR = 8'h93;
    localparam logic [7:0] CODE_GLOBAL_RD      = 8'h14;
    localparam logic [7:0] CODE_GLOBAL_WR      = 8'h94;
    localparam logic [7:0] CODE_PORT1_RD       = 8'h15;
    localparam logic [7:0] CODE_PORT1_WR       = 8'h95;
    localparam logic [7:0] CODE_PORT2_RD       = 8'h16;
    localparam logic [7:0] CODE_PORT2_WR       = 8'h96;
    localparam int         CODE_WRITE_BIT      = 7;

    // First descriptor field positions
    localparam int PGD_MSB      = 31;
    localparam int PGD_LSB      = 24;
    localparam int NO_OVERCURRENT_REPORT_BIT     = 12;
    localparam int OCMODE_BIT   = 11;
    localparam int COMPOUND_BIT = 10;
    localparam int ALWAYS_BIT   = 9;
    localparam int SWMODE_BIT   = 8;
    localparam int NDP_MSB      = 1;

    // Second descriptor mask field, bit 0 of it reserved
    localparam int MASK_MSB = 18;
    localparam int MASK_LSB = 17;

    // Hub and port status bits
    localparam int GLB_CLR_POWER_BIT = 0;
    localparam int GLB_OCI_BIT       = 1;
    localparam int GLB_SET_POWER_BIT = 16;
    localparam int PRT_OCI_BIT       = 3;
    localparam int PRT_SET_POWER_BIT = 8;
    localparam int PRT_CLR_POWER_BIT = 9;

    // Reset values of the implementation-specific fields
    localparam logic [7:0] RST_PGD      = 8'h01;
    localparam logic       RST_NO_OVERCURRENT_REPORT     = 1'b0;
    localparam logic       RST_ALWAYS   = 1'b0;
    localparam logic       RST_SWMODE   = 1'b1;
    localparam logic [1:0] RST_MASK     = 2'h0;
    localparam logic [1:0] PORT_COUNT   = 2'h2;
    localparam logic [1:0] PORT_MAX     = 2'h2;

    localparam logic [1:0] HC_OPERATIONAL = 2'h2;

    // Power-good delay unit
    localparam int PGD_UNIT_NS    = 2000000;
    localparam int CLK_PERIOD_NS  = 10;
    localparam int PGD_UNIT_CYC   = PGD_UNIT_NS / CLK_PERIOD_NS;
    localparam int TICK_W         = 18;
endpackage

// ### core/rhd_port_power.sv
// Power switch state of one root hub port
`timescale 1ns/1ps
module rhd_port_power
(
    input  wire logic REF_CLK,
    input  wire logic RST,
    input  wire logic always_powered,
    input  wire logic individual_mode,
    input  wire logic mask,
    input  wire logic set_global,
    input  wire logic clr_global,
    input  wire logic set_port,
    input  wire logic clr_port,
    output logic      powered
);
    logic per_port;

    // Masked ports in individual mode answer port commands only
    assign per_port = individual_mode & mask;

    always_ff @(posedge REF_CLK)
    begin
        if (RST)
            powered <= 1'b0;
        else if (always_powered)
            powered <= 1'b1;
        else if (per_port)
        begin
            if (set_port)
                powered <= 1'b1;
            else if (clr_port)
                powered <= 1'b0;
        end
        else
        begin
            if (set_global)
                powered <= 1'b1;
            else if (clr_global)
                powered <= 1'b0;
        end
    end
endmodule

// ### core/rhd_regs.sv
// Root hub descriptor registers, write gating and port power
`timescale 1ns/1ps

// Overview of operation
// - Registers are 32 bits, whole-word access only
// - Descriptor writes accepted in every state
// - Status writes accepted only when operational
// - First descriptor read 12H, written 92H
// - Bits 31:24 power-good delay, 2 ms units
// - Bit 12 set disables overcurrent reporting
// - Overcurrent mode resets equal to switching mode
// - Mode 0 collective, 1 per-port reporting
// - Compound flag bit 10 reads zero always
// - Bit 9 set keeps ports always powered
// - Bit 8 chooses ganged or individual switching
// - Bits 1:0 read-only port count, max 2
// - Mask in second descriptor bits 18:16
module rhd_regs
#(
    parameter int unsigned PGD_UNIT_CYCLES = rhd_pkg::PGD_UNIT_CYC
)
(
    input  wire logic                      REF_CLK,
    input  wire logic                      RST,
    input  wire logic                      CMD_STROBE,
    input  wire logic [rhd_pkg::CODE_W-1:0] CMD_CODE,
    input  wire logic [rhd_pkg::DATA_W-1:0] CMD_WDATA,
    input  wire logic [1:0]                HC_STATE,
    input  wire logic [rhd_pkg::PORTS-1:0] OVERCURRENT,
    output logic      [rhd_pkg::DATA_W-1:0] RD_DATA,
    output logic                           RD_VALID,
    output logic                           WR_REFUSED,
    output logic      [rhd_pkg::PORTS-1:0] PORT_POWER,
    output logic                           POWER_GOOD,
    output logic                           OC_GLOBAL,
    output logic      [rhd_pkg::PORTS-1:0] OC_PORT
);
    import rhd_pkg::*;

    logic [7:0]        power_good_delay;
    logic              no_overcurrent_report;
    logic              overcurrent_report_mode;
    logic              always_powered;
    logic              switching_mode_select;
    logic [1:0]        port_power_mask;
    logic              operational_state;
    logic              is_write;
    logic              wr_first;
    logic              wr_second;
    logic              wr_global;
    logic [PORTS-1:0]  wr_port;
    logic              wr_status_any;
    logic              status_ok;
    logic              set_global;
    logic              clr_global;
    logic [PORTS-1:0]  set_port;
    logic [PORTS-1:0]  clr_port;
    logic [PORTS-1:0]  port_powered;
    logic [PORTS-1:0]  powered_q;
    logic              power_rise;
    logic [TICK_W-1:0] tick_cnt;
    logic              tick;
    logic [7:0]        pgd_cnt;
    logic [DATA_W-1:0] next_rd_data;
    logic              oc_collective;
    logic [PORTS-1:0]  oc_per_port;
    logic [1:0]        port_count;
    logic [DATA_W-1:0] desc_first_word;
    logic [DATA_W-1:0] desc_second_word;

    assign is_write          = CMD_STROBE & CMD_CODE[CODE_WRITE_BIT];
    assign operational_state = (HC_STATE == HC_OPERATIONAL);
    // Descriptor writes are never gated by controller state
    assign wr_first  = CMD_STROBE && CMD_CODE == CODE_DESC_FIRST_WR;
    assign wr_second = CMD_STROBE && CMD_CODE == CODE_DESC_SECOND_WR;
    assign wr_global  = CMD_STROBE && CMD_CODE == CODE_GLOBAL_WR;
    assign wr_port[0] = CMD_STROBE && CMD_CODE == CODE_PORT1_WR;
    assign wr_port[1] = CMD_STROBE && CMD_CODE == CODE_PORT2_WR;
    assign wr_status_any = wr_global | (|wr_port);
    assign status_ok     = operational_state;

    // Refused status writes produce no command at all
    assign set_global = wr_global & status_ok
                        & CMD_WDATA[GLB_SET_POWER_BIT];
    assign clr_global = wr_global & status_ok
                        & CMD_WDATA[GLB_CLR_POWER_BIT];
    assign set_port = wr_port & {PORTS{status_ok
                        & CMD_WDATA[PRT_SET_POWER_BIT]}};
    assign clr_port = wr_port & {PORTS{status_ok
                        & CMD_WDATA[PRT_CLR_POWER_BIT]}};

    // Count is fixed but clamped so it can never read above two
    assign port_count = (PORT_COUNT > PORT_MAX) ? PORT_MAX
                                                : PORT_COUNT;

    // First descriptor: whole word taken in one write
    always_ff @(posedge REF_CLK)
    begin
        if (RST)
            power_good_delay <= RST_PGD;
        else if (wr_first)
            power_good_delay <= CMD_WDATA[PGD_MSB:PGD_LSB];
    end

    // Overcurrent reporting bits, mode resets to the switching mode
    always_ff @(posedge REF_CLK)
    begin
        if (RST)
        begin
            no_overcurrent_report   <= RST_NO_OVERCURRENT_REPORT;
            overcurrent_report_mode <= RST_SWMODE;
        end
        else if (wr_first)
        begin
            no_overcurrent_report   <= CMD_WDATA[NO_OVERCURRENT_REPORT_BIT];
            overcurrent_report_mode <= CMD_WDATA[OCMODE_BIT];
        end
    end

    // Power switching bits
    always_ff @(posedge REF_CLK)
    begin
        if (RST)
        begin
            always_powered        <= RST_ALWAYS;
            switching_mode_select <= RST_SWMODE;
        end
        else if (wr_first)
        begin
            always_powered        <= CMD_WDATA[ALWAYS_BIT];
            switching_mode_select <= CMD_WDATA[SWMODE_BIT];
        end
    end

    // Second descriptor: only the port power mask is kept
    always_ff @(posedge REF_CLK)
    begin
        if (RST)
            port_power_mask <= RST_MASK;
        else if (wr_second)
            port_power_mask <= CMD_WDATA[MASK_MSB:MASK_LSB];
    end

    genvar p;
    generate
        for (p = 0; p < PORTS; p++)
        begin : g_port
            rhd_port_power u_power
            (
                .REF_CLK         (REF_CLK),
                .RST             (RST),
                .always_powered  (always_powered),
                .individual_mode (switching_mode_select),
                .mask            (port_power_mask[p]),
                .set_global      (set_global),
                .clr_global      (clr_global),
                .set_port        (set_port[p]),
                .clr_port        (clr_port[p]),
                .powered         (port_powered[p])
            );
        end
    endgenerate

    always_ff @(posedge REF_CLK)
    begin
        if (RST)
        begin
            PORT_POWER <= '0;
            powered_q  <= '0;
        end
        else
        begin
            PORT_POWER <= port_powered;
            powered_q  <= port_powered;
        end
    end

    assign power_rise = |(port_powered & ~powered_q);

    // 2 ms unit prescaler, restarted on power-up so each unit is full
    always_ff @(posedge REF_CLK)
    begin
        if (RST || power_rise)
            tick_cnt <= '0;
        else if (tick)
            tick_cnt <= '0;
        else
            tick_cnt <= tick_cnt + TICK_W'(1);
    end

    assign tick = (tick_cnt == TICK_W'(PGD_UNIT_CYCLES - 1));

    // Power-good countdown in delay units, a hint for the driver's wait
    always_ff @(posedge REF_CLK)
    begin
        if (RST)
            pgd_cnt <= '0;
        else if (power_rise)
            pgd_cnt <= power_good_delay;
        else if (tick && pgd_cnt != 8'h00)
            pgd_cnt <= pgd_cnt - 8'h01;
    end

    always_ff @(posedge REF_CLK)
    begin
        if (RST)
            POWER_GOOD <= 1'b0;
        else
            POWER_GOOD <= (|port_powered) && !power_rise
                          && pgd_cnt == 8'h00;
    end

    // Overcurrent reporting per descriptor mode
    assign oc_collective = !no_overcurrent_report
                           && !overcurrent_report_mode
                           && (|OVERCURRENT);
    assign oc_per_port = (!no_overcurrent_report
                          && overcurrent_report_mode)
                         ? OVERCURRENT : '0;

    always_ff @(posedge REF_CLK)
    begin
        if (RST)
        begin
            OC_GLOBAL <= 1'b0;
            OC_PORT   <= '0;
        end
        else
        begin
            OC_GLOBAL <= oc_collective;
            OC_PORT   <= oc_per_port;
        end
    end

    // Fixed and reserved fields are tied here, so no write data
    // can ever reach them
    always_comb
    begin
        desc_first_word                  = '0;
        desc_first_word[PGD_MSB:PGD_LSB] = power_good_delay;
        desc_first_word[NO_OVERCURRENT_REPORT_BIT]        = no_overcurrent_report;
        desc_first_word[OCMODE_BIT]      = overcurrent_report_mode;
        desc_first_word[COMPOUND_BIT]    = 1'b0;
        desc_first_word[ALWAYS_BIT]      = always_powered;
        desc_first_word[SWMODE_BIT]      = switching_mode_select;
        desc_first_word[NDP_MSB:0]       = port_count;
    end

    // Lowest mask bit is reserved and reads zero
    always_comb
    begin
        desc_second_word                    = '0;
        desc_second_word[MASK_MSB:MASK_LSB] = port_power_mask;
    end

    // Read multiplexer; unknown codes read as zero
    always_comb
    begin
        next_rd_data = '0;
        unique case (CMD_CODE)
            CODE_DESC_FIRST_RD:
                next_rd_data = desc_first_word;
            CODE_DESC_SECOND_RD:
                next_rd_data = desc_second_word;
            CODE_GLOBAL_RD:
                next_rd_data[GLB_OCI_BIT] = OC_GLOBAL;
            CODE_PORT1_RD:
            begin
                next_rd_data[PRT_OCI_BIT]       = OC_PORT[0];
                next_rd_data[PRT_SET_POWER_BIT] = PORT_POWER[0];
            end
            CODE_PORT2_RD:
            begin
                next_rd_data[PRT_OCI_BIT]       = OC_PORT[1];
                next_rd_data[PRT_SET_POWER_BIT] = PORT_POWER[1];
            end
            default:
                next_rd_data = '0;
        endcase
    end

    // Read answer one cycle after the strobe, held until next read
    always_ff @(posedge REF_CLK)
    begin
        if (RST)
        begin
            RD_DATA  <= '0;
            RD_VALID <= 1'b0;
        end
        else
        begin
            RD_VALID <= CMD_STROBE && !is_write;
            if (CMD_STROBE && !is_write)
                RD_DATA <= next_rd_data;
        end
    end

    // Flags a status write that was dropped outside operational state
    always_ff @(posedge REF_CLK)
    begin
        if (RST)
            WR_REFUSED <= 1'b0;
        else
            WR_REFUSED <= wr_status_any && !status_ok;
    end
endmodule

// ### verif/rhd_regs_monitor.sv
// Assertion checker for the descriptor register bank
`timescale 1ns/1ps
module rhd_regs_monitor
#(
    parameter int unsigned PGD_UNIT_CYCLES = 4
)
(
    input wire logic        REF_CLK,
    input wire logic        RST,
    input wire logic        CMD_STROBE,
    input wire logic [7:0]  CMD_CODE,
    input wire logic [31:0] CMD_WDATA,
    input wire logic [1:0]  HC_STATE,
    input wire logic [1:0]  OVERCURRENT,
    input wire logic [31:0] RD_DATA,
    input wire logic        RD_VALID,
    input wire logic        WR_REFUSED,
    input wire logic [1:0]  PORT_POWER,
    input wire logic        POWER_GOOD,
    input wire logic        OC_GLOBAL,
    input wire logic [1:0]  OC_PORT
);
    import rhd_pkg::*;
    logic [31:0] desc;
    logic [31:0] wd;
    logic        stat_wr;
    logic        oc_g;
    logic [1:0]  oc_p;
    assign stat_wr = CMD_STROBE && (CMD_CODE == CODE_GLOBAL_WR
        || CMD_CODE == CODE_PORT1_WR || CMD_CODE == CODE_PORT2_WR);
    assign oc_g = |OVERCURRENT && !desc[NO_OVERCURRENT_REPORT_BIT] && !desc[OCMODE_BIT];
    assign oc_p = (!desc[NO_OVERCURRENT_REPORT_BIT] && desc[OCMODE_BIT]) ? OVERCURRENT : 2'h0;
    // Shadow of the first descriptor, reset mode copied from switching mode
    always_ff @(posedge REF_CLK)
    begin
        if (RST)
            desc <= {RST_PGD, 11'h0, RST_NO_OVERCURRENT_REPORT, RST_SWMODE, 1'b0,
                     RST_ALWAYS, RST_SWMODE, 8'h00};
        else if (CMD_STROBE && CMD_CODE == CODE_DESC_FIRST_WR)
            desc <= CMD_WDATA;
    end
    always_ff @(posedge REF_CLK)
    begin
        if (CMD_STROBE && CMD_CODE[CODE_WRITE_BIT])
            wd <= CMD_WDATA;
    end
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (RST);
    sequence s_write_read;
        CMD_STROBE && CMD_CODE == CODE_DESC_FIRST_WR
        ##1 CMD_STROBE && CMD_CODE == CODE_DESC_FIRST_RD;
    endsequence
    // Quiet before and after, so no legal power change is in flight
    sequence s_refused;
        !CMD_STROBE [*2] ##1 stat_wr && HC_STATE != HC_OPERATIONAL
        ##1 !CMD_STROBE;
    endsequence
    chk_read_answer: assert property (
        CMD_STROBE && !CMD_CODE[7] |=> RD_VALID && !WR_REFUSED)
        else $error("read strobe not answered");
    chk_fixed_fields: assert property (
        CMD_STROBE && CMD_CODE == CODE_DESC_FIRST_RD |=>
        RD_DATA[1:0] == PORT_COUNT && RD_DATA[23:13] == 11'h0
        && !RD_DATA[10] && RD_DATA[7:2] == 6'h0)
        else $error("fixed descriptor fields wrong");
    chk_write_echo: assert property (
        s_write_read |=> RD_DATA[31:24] == wd[31:24]
        && RD_DATA[12:11] == wd[12:11] && RD_DATA[9:8] == wd[9:8])
        else $error("descriptor write not read back");
    chk_refuse_flag: assert property (
        stat_wr |=> WR_REFUSED == ($past(HC_STATE) != HC_OPERATIONAL))
        else $error("status write refusal wrong");
    chk_refused_hold: assert property (
        s_refused |=> $stable(PORT_POWER) [*2])
        else $error("refused write changed port power");
    chk_always_on: assert property (
        $rose(desc[ALWAYS_BIT]) |-> ##[1:3] PORT_POWER == 2'h3)
        else $error("always powered ports not on");
    chk_good_wait: assert property (
        $rose(|PORT_POWER) |-> !POWER_GOOD [*3])
        else $error("power good too early");
    chk_oc_global: assert property (
        OC_GLOBAL == $past(oc_g))
        else $error("collective overcurrent wrong");
    chk_oc_port: assert property (
        OC_PORT == $past(oc_p))
        else $error("per-port overcurrent wrong");
endmodule
bind rhd_regs rhd_regs_monitor #(.PGD_UNIT_CYCLES(PGD_UNIT_CYCLES))
    rhd_regs_monitor_inst (.REF_CLK(REF_CLK), .RST(RST),
    .CMD_STROBE(CMD_STROBE), .CMD_CODE(CMD_CODE), .CMD_WDATA(CMD_WDATA),
    .HC_STATE(HC_STATE), .OVERCURRENT(OVERCURRENT), .RD_DATA(RD_DATA),
    .RD_VALID(RD_VALID), .WR_REFUSED(WR_REFUSED), .PORT_POWER(PORT_POWER),
    .POWER_GOOD(POWER_GOOD), .OC_GLOBAL(OC_GLOBAL), .OC_PORT(OC_PORT));

// ### verif/rhd_host_model.sv
// Host driver model issuing whole-word register commands
`timescale 1ns/1ps
module rhd_host_model
(
    input  wire logic        ref_clk,
    input  wire logic [31:0] rd_data,
    input  wire logic        rd_valid,
    input  wire logic        wr_refused,
    input  wire logic        power_good,
    output logic             cmd_strobe,
    output logic [7:0]       cmd_code,
    output logic [31:0]      cmd_wdata
);
    import rhd_pkg::*;
    initial
    begin
        cmd_strobe = 1'b0;
        cmd_code   = 8'h00;
        cmd_wdata  = 32'h0;
    end
    task automatic send(input logic [7:0] c, input logic [31:0] d);
        @(negedge ref_clk);
        cmd_strobe = 1'b1;
        cmd_code   = c;
        cmd_wdata  = d;
    endtask
    // Released bus never shows the last word
    task automatic idle(output logic [31:0] q, output logic v,
                        output logic r);
        @(negedge ref_clk);
        cmd_strobe = 1'b0;
        cmd_code   = ~cmd_code;
        cmd_wdata  = ~cmd_wdata;
        q = rd_data;
        v = rd_valid;
        r = wr_refused;
    endtask
    task automatic ocmode_init(input logic [31:0] d);
        logic [31:0] q;
        logic        v;
        logic        r;
        send(CODE_DESC_FIRST_WR, d & ~32'h0000_0800);
        send(CODE_DESC_FIRST_WR, d);
        idle(q, v, r);
    endtask
    // Port is touched after its power-good time, or after 1000 cycles if power good never comes
    task automatic wait_good(output int n);
        n = 0;
        while (power_good !== 1'b1 && n < 1000)
        begin
            @(negedge ref_clk);
            n++;
        end
    endtask
endmodule

// ### verif/rhd_regs_tb_top.sv
// Self-checking bench for the descriptor register bank
`timescale 1ns/1ps
module rhd_regs_tb_top;
    import rhd_pkg::*;
    localparam int UNIT = 4;
    logic        ref_clk, rst, cmd_strobe, rd_valid, wr_refused, v, r;
    logic        power_good, oc_global;
    logic [7:0]  cmd_code;
    logic [31:0] cmd_wdata, rd_data, q;
    logic [1:0]  hc_state, overcurrent, port_power, oc_port;
    int          num_errors = 0;
    int          n_tests = 0;
    int          cycles = 0;
    int          n;
    rhd_regs #(.PGD_UNIT_CYCLES(UNIT)) rhd_regs_inst (
        .REF_CLK(ref_clk), .RST(rst), .CMD_STROBE(cmd_strobe),
        .CMD_CODE(cmd_code), .CMD_WDATA(cmd_wdata), .HC_STATE(hc_state),
        .OVERCURRENT(overcurrent), .RD_DATA(rd_data), .RD_VALID(rd_valid),
        .WR_REFUSED(wr_refused), .PORT_POWER(port_power),
        .POWER_GOOD(power_good), .OC_GLOBAL(oc_global), .OC_PORT(oc_port));
    rhd_host_model rhd_host_model_inst (.ref_clk(ref_clk),
        .rd_data(rd_data), .rd_valid(rd_valid), .wr_refused(wr_refused),
        .power_good(power_good), .cmd_strobe(cmd_strobe),
        .cmd_code(cmd_code), .cmd_wdata(cmd_wdata));
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic finish_test();
        $display("checks %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Whole run is about 120 cycles
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            num_errors++;
            finish_test();
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask
    task automatic cmd(input logic [7:0] c, input logic [31:0] d);
        rhd_host_model_inst.send(c, d);
        rhd_host_model_inst.idle(q, v, r);
    endtask
    task automatic wait_cyc(input int k);
        repeat (k) @(negedge ref_clk);
    endtask
    task automatic t_reset();
        cmd(CODE_DESC_FIRST_RD, 32'h0);
        check(v, 1'b1);
        check(q, {RST_PGD, 11'h0, RST_NO_OVERCURRENT_REPORT, RST_SWMODE, 1'b0, RST_ALWAYS,
                  RST_SWMODE, 6'h0, PORT_COUNT});
        cmd(CODE_DESC_SECOND_RD, 32'h0);
        check(q, {13'h0, RST_MASK, 17'h0});
        $display("test reset values done");
    endtask
    task automatic t_desc_rw();
        logic [31:0] pat [2] = '{32'hFFFF_FFFF, 32'h0300_0000};
        foreach (pat[i])
        begin
            rhd_host_model_inst.send(CODE_DESC_FIRST_WR, pat[i]);
            cmd(CODE_DESC_FIRST_RD, 32'h0);
            check(q, pat[i] & 32'hFF00_1B00 | 32'h2);
        end
        $display("test descriptor access done");
    endtask
    task automatic t_overcurrent();
        overcurrent = 2'h2;
        for (int i = 0; i < 4; i++)
        begin
            rhd_host_model_inst.ocmode_init(
                {8'h03, 11'h0, i[1:0], 3'b001, 8'h00});
            wait_cyc(2);
            check(oc_global, !i[1] && !i[0]);
            check(oc_port, (!i[1] && i[0]) ? 2'h2 : 2'h0);
            cmd(CODE_GLOBAL_RD, 32'h0);
            check(q[GLB_OCI_BIT], !i[1] && !i[0]);
            cmd(CODE_PORT2_RD, 32'h0);
            check(q[PRT_OCI_BIT], !i[1] && i[0]);
        end
        overcurrent = 2'h0;
        $display("test overcurrent modes done");
    endtask
    task automatic t_refuse_power();
        // Ports are still on from the always-powered pattern
        hc_state = HC_OPERATIONAL;
        cmd(CODE_GLOBAL_WR, 32'h0000_0001);
        wait_cyc(2);
        check(port_power, 2'h0);
        hc_state = 2'h0;
        wait_cyc(2);
        cmd(CODE_GLOBAL_WR, 32'h0001_0000);
        check(r, 1'b1);
        wait_cyc(3);
        check(port_power, 2'h0);
        hc_state = HC_OPERATIONAL;
        cmd(CODE_GLOBAL_WR, 32'h0001_0000);
        check(r, 1'b0);
        rhd_host_model_inst.wait_good(n);
        check(n >= 3 * UNIT - 1 && n <= 3 * UNIT + 4, 1'b1);
        cmd(CODE_PORT1_RD, 32'h0);
        check(q[PRT_SET_POWER_BIT], 1'b1);
        $display("test status write gating done");
    endtask
    task automatic t_mask();
        logic [7:0]  c [8] = '{CODE_GLOBAL_WR, CODE_PORT1_WR,
            CODE_GLOBAL_WR, CODE_PORT1_WR, CODE_PORT2_WR,
            CODE_DESC_FIRST_WR, CODE_GLOBAL_WR, CODE_PORT1_WR};
        logic [31:0] d [8] = '{32'h1, 32'h200, 32'h10000, 32'h100,
            32'h200, 32'h0300_0000, 32'h1, 32'h100};
        logic [1:0]  e [8] = '{2'h1, 2'h0, 2'h2, 2'h3, 2'h3, 2'h3, 2'h0,
            2'h0};
        cmd(CODE_DESC_SECOND_WR, 32'h0002_0000);
        cmd(CODE_DESC_SECOND_RD, 32'h0);
        check(q, 32'h0002_0000);
        foreach (c[i])
        begin
            cmd(c[i], d[i]);
            wait_cyc(2);
            check(port_power, e[i]);
        end
        cmd(CODE_DESC_FIRST_WR, 32'h0300_0200);
        wait_cyc(2);
        check(port_power, 2'h3);
        $display("test power switching done");
    endtask
    initial
    begin
        rst = 1'b1;
        hc_state = 2'h0;
        overcurrent = 2'h0;
        repeat (6) @(negedge ref_clk);
        rst = 1'b0;
        t_reset();
        t_desc_rw();
        t_overcurrent();
        t_refuse_power();
        t_mask();
        finish_test();
    end
endmodule
